// [rtl/dpbs_consts.svh]
// Purpose: Constants of the dual-port burst memory device: widths, latencies, register map.
// Assumes: Included by the package and by the monitor.
// Notes:   Latencies are counted in rising edges of either timing input.
`ifndef DPBS_CONSTS_SVH
`define DPBS_CONSTS_SVH

// Array geometry
`define DPBS_ADDR_W      8
`define DPBS_WORD_W      36
`define DPBS_LANES       4
`define DPBS_LANE_W      9
`define DPBS_BEAT_W      2
`define DPBS_LAST_BEAT   2'h3
`define DPBS_FIRST_BEAT  2'h0
`define DPBS_BEAT_ONE    2'h1

// Read latency, in timing-input edges, and the pipeline tap that fires the first word
`define DPBS_PIPE_LEN    5
`define DPBS_TAP_PLL_USE 3'h4
`define DPBS_TAP_PLL_OFF 3'h1

// APB register map (byte addresses)
`define DPBS_PADDR_W     12
`define DPBS_OFS_CTRL    12'h000
`define DPBS_OFS_STATUS  12'h004
`define DPBS_OFS_RDCNT   12'h008
`define DPBS_OFS_WRCNT   12'h00C

// Field positions and reset values
`define DPBS_CTRL_EN_BIT     0
`define DPBS_CTRL_RST        1'b1
`define DPBS_ST_RD_BIT       0
`define DPBS_ST_WR_BIT       1
`define DPBS_ST_PLL_BIT      2
`define DPBS_ST_PH_BIT       3
`define DPBS_CNT_W           16
`define DPBS_CNT_ONE         16'h0001

`endif

// [rtl/dpbs_pkg.sv]
// Purpose: Types and shared helpers of the dual-port burst memory device.
// Assumes: Constants come from dpbs_consts.svh.
// Notes:   Whole state of the top module is one packed struct.
`include "dpbs_consts.svh"

package dpbs_pkg;

   typedef logic [`DPBS_WORD_W-1:0]              dpbs_word_type;
   typedef logic [`DPBS_ADDR_W-1:0]              dpbs_addr_type;
   typedef logic [`DPBS_ADDR_W+`DPBS_BEAT_W-1:0] dpbs_widx_type;

   // Which kind of address the next primary rising edge carries
   typedef enum logic [1:0]
   {
      DPBS_PH_READ  = 2'b01,
      DPBS_PH_WRITE = 2'b10
   } dpbs_phase_type;

   // Burst engine state, used by both ports
   typedef enum logic [1:0]
   {
      DPBS_BU_IDLE = 2'b01,
      DPBS_BU_RUN  = 2'b10
   } dpbs_burst_type;

   typedef struct packed
   {
      logic                                k_q;       // Last sample of primary timing input
      logic                                kn_q;      // Last sample of complement timing input
      dpbs_phase_type                      phase;     // Slot of next primary rising edge
      logic [`DPBS_PIPE_LEN-1:0]           rpv;       // Read latency pipe, valid bits
      logic [`DPBS_PIPE_LEN-1:0][`DPBS_ADDR_W-1:0] rpa; // Read latency pipe, addresses
      dpbs_burst_type                      rd_st;     // Read burst engine
      dpbs_addr_type                       rd_addr;   // Address of read burst in flight
      logic [`DPBS_BEAT_W-1:0]             rd_cnt;    // Next read word within burst
      dpbs_burst_type                      wr_st;     // Write burst engine
      dpbs_addr_type                       wr_addr;   // Address of write burst in flight
      logic [`DPBS_BEAT_W-1:0]             wr_cnt;    // Next write word within burst
      dpbs_word_type                       q;         // Read data output register
      logic                                qv;        // Read-valid output register
      logic                                echo_p;    // Echo timing output
      logic                                echo_n;    // Complement echo timing output
      logic                                ctrl_en;   // Software port enable
      logic [`DPBS_CNT_W-1:0]              rd_bursts; // Accepted read addresses
      logic [`DPBS_CNT_W-1:0]              wr_bursts; // Accepted write addresses
      logic [31:0]                         prdata;    // APB read data
      logic                                pready;    // APB ready
      logic                                pslverr;   // APB error
   } dpbs_state_type;

   // Lane merge: lanes with a set mask bit take new data, others keep old data
   function automatic dpbs_word_type dpbs_merge(input dpbs_word_type          old_w,
                                                input dpbs_word_type          new_w,
                                                input logic [`DPBS_LANES-1:0] mask);
      dpbs_word_type res;
      res = old_w;
      for (int i = 0; i < `DPBS_LANES; i++)
      begin
         if (mask[i])
         begin
            res[i*`DPBS_LANE_W +: `DPBS_LANE_W] = new_w[i*`DPBS_LANE_W +: `DPBS_LANE_W];
         end
      end
      return res;
   endfunction

endpackage

// [rtl/dpbs_mem_if.sv]
// Purpose: Link between the port logic and the storage array.
// Assumes: One write port and one asynchronous read port.
// Notes:   Write takes effect at the clock edge where we is high.
`timescale 1ns/1ps

interface dpbs_mem_if;
   import dpbs_pkg::*;

   logic                   we;      // Write strobe, one cycle
   dpbs_widx_type          waddr;   // Word index to write
   dpbs_word_type          wdata;   // Word to write
   logic [`DPBS_LANES-1:0] wmask;   // Lanes to write, active high
   dpbs_widx_type          raddr;   // Word index to read
   dpbs_word_type          rdata;   // Word read, combinational

   modport ctrl (output we, output waddr, output wdata, output wmask, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input wmask, input raddr, output rdata);
endinterface

// [rtl/dpbs_array.sv]
// Purpose: Storage array of four-word locations with per-lane write.
// Assumes: Single clock, writes already merged by lane mask here.
// Notes:   Array content has no reset; read is asynchronous so the port logic
//          can register it straight into the output word.
`timescale 1ns/1ps

module dpbs_array
   import dpbs_pkg::*;
(
   input  wire logic  pclk,
   dpbs_mem_if.mem    mif
);

   // Four words per location, flattened into word indices
   dpbs_word_type mem_q [0:(1<<(`DPBS_ADDR_W+`DPBS_BEAT_W))-1];

   // Lane-masked write; untouched lanes keep their bytes
   always_ff @(posedge pclk)
   begin
      if (mif.we)
      begin
         mem_q[mif.waddr] <= dpbs_merge(mem_q[mif.waddr], mif.wdata, mif.wmask);
      end
   end

   // Asynchronous read
   assign mif.rdata = mem_q[mif.raddr];

endmodule

// [rtl/dpbs_top.sv]
// Purpose: Device side of a dual-port double-data-rate burst memory with APB status access.
// Assumes: Timing inputs and all pins are synchronous to pclk and sampled by it;
//          pclk runs far faster than the timing inputs.
// Notes:   An "edge" below is a rising edge of either timing input as seen in pclk.
`timescale 1ns/1ps

// Behaviour
// R01: Separate read outputs and write inputs
// R02: Shared address, read and write slots alternate
// R03: Each address holds four 36-bit words
// R04: One word per rising edge of either input
// R05: Only rising timing edges have meaning
// R06: PLL disable high gives 2.5-cycle latency
// R07: PLL disable low gives one-cycle latency
// R08: Read-valid flag marks output data words
// R09: Echo pair aligned with read data
// R10: Read and write engines run independently
// R11: Separate port selects per port
// R12: All inputs and data outputs registered
// R13: Writes complete internally, self-timed
// R14: Reads return newest data, even in-flight
// R15: Write select low starts write burst
// R16: Byte selects gate 9-bit lanes
// R17: Words move in ascending order
module dpbs_top
   import dpbs_pkg::*;
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`DPBS_PADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     k_in,
   input  wire logic                     k_n_in,
   input  wire logic [`DPBS_ADDR_W-1:0]  addr,
   input  wire logic                     read_port_select_n,
   input  wire logic                     write_port_select_n,
   input  wire logic [`DPBS_LANES-1:0]   byte_write_select_n,
   input  wire logic [`DPBS_WORD_W-1:0]  data_in,
   input  wire logic                     pll_disable,
   output logic      [`DPBS_WORD_W-1:0]  data_out,
   output logic                          read_valid_flag,
   output logic                          echo_timing_output,
   output logic                          echo_timing_output_n
);

   dpbs_state_type s_q;          // Registered state
   dpbs_state_type s_d;          // Next state
   dpbs_mem_if     mif ();       // Link to the storage array

   logic                   k_rise;    // Primary timing input rose
   logic                   kn_rise;   // Complement timing input rose
   logic                   any_rise;  // Either rose: one data beat
   logic [2:0]             tap;       // Latency pipe tap for the first read word
   logic                   rd_first;  // First read word launches this cycle
   logic                   wr_beat;   // Write word captured this cycle
   dpbs_widx_type          raddr_c;   // Read word index
   dpbs_widx_type          waddr_c;   // Write word index
   logic [`DPBS_LANES-1:0] wmask_c;   // Active lanes of this write word
   dpbs_word_type          rword_c;   // Read word after bypass
   logic                   apb_wr;    // APB write completes this cycle
   logic                   apb_setup; // APB setup phase

   // Only rising edges of the two timing inputs are decoded [R05]
   assign k_rise   = k_in & ~s_q.k_q;                                     // [R05]
   assign kn_rise  = k_n_in & ~s_q.kn_q;                                  // [R05]
   assign any_rise = k_rise | kn_rise;                                    // [R04]

   // Latency choice: five edges with PLL disable high, two edges with it low
   assign tap      = pll_disable ? `DPBS_TAP_PLL_USE : `DPBS_TAP_PLL_OFF; // [R06] [R07]
   assign rd_first = any_rise & s_q.rpv[tap];

   // Word index: location plus ascending beat number [R03] [R17]
   assign raddr_c = rd_first ? {s_q.rpa[tap], `DPBS_FIRST_BEAT} : {s_q.rd_addr, s_q.rd_cnt}; // [R17]
   assign waddr_c = {s_q.wr_addr, s_q.wr_cnt};                                               // [R17]

   // A write word is taken on every edge of a running write burst [R04]
   assign wr_beat = any_rise & (s_q.wr_st == DPBS_BU_RUN);
   assign wmask_c = ~byte_write_select_n;                                 // [R16]

   // Self-timed commit: each word lands in the array at its own edge [R13]
   assign mif.we    = wr_beat;                                            // [R13]
   assign mif.waddr = waddr_c;
   assign mif.wdata = data_in;
   assign mif.wmask = wmask_c;                                            // [R16]
   assign mif.raddr = raddr_c;

   // Same-cycle write to the word being read is forwarded so reads see newest data
   assign rword_c = (wr_beat && (waddr_c == raddr_c))
                    ? dpbs_merge(mif.rdata, data_in, wmask_c)             // [R14]
                    : mif.rdata;

   // APB phase decode
   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & s_q.pready & pwrite;

   dpbs_array u_array
   (
      .pclk (pclk),
      .mif  (mif)
   );

   // Next-state logic for the whole device
   always_comb
   begin
      s_d = s_q;

      // Input registers: timing samples and echo pair track the inputs [R12]
      s_d.k_q    = k_in;                                                  // [R12]
      s_d.kn_q   = k_n_in;                                                // [R12]
      // Echo pair is registered in the same cycle as the data word [R09]
      s_d.echo_p = k_in;                                                  // [R09]
      s_d.echo_n = k_n_in;                                                // [R09]

      // Read latency pipe advances one step per edge
      if (any_rise)
      begin
         s_d.rpv = {s_q.rpv[`DPBS_PIPE_LEN-2:0], 1'b0};
         s_d.rpa = {s_q.rpa[`DPBS_PIPE_LEN-2:0], {`DPBS_ADDR_W{1'b0}}};
      end

      // Address slots alternate on primary rising edges [R02]
      if (k_rise)
      begin
         unique case (s_q.phase)
            DPBS_PH_READ:
            begin
               s_d.phase = DPBS_PH_WRITE;                                 // [R02]
               // Read select gates only this port [R11]
               if (!read_port_select_n && s_q.ctrl_en)                    // [R11]
               begin
                  s_d.rpv[0]    = 1'b1;
                  s_d.rpa[0]    = addr;
                  s_d.rd_bursts = s_q.rd_bursts + `DPBS_CNT_ONE;
               end
            end
            DPBS_PH_WRITE:
            begin
               s_d.phase = DPBS_PH_READ;                                  // [R02]
               // Write select low opens a burst; high leaves data ignored [R15] [R11]
               if (!write_port_select_n && s_q.ctrl_en)                   // [R15]
               begin
                  s_d.wr_bursts = s_q.wr_bursts + `DPBS_CNT_ONE;
               end
            end
         endcase
      end

      // Read engine: first word from the pipe tap, then three more [R10]
      if (any_rise)
      begin
         if (rd_first)
         begin
            s_d.q       = rword_c;                                        // [R01]
            s_d.qv      = 1'b1;                                           // [R08]
            s_d.rd_st   = DPBS_BU_RUN;
            s_d.rd_addr = s_q.rpa[tap];
            s_d.rd_cnt  = `DPBS_BEAT_ONE;
         end
         else if (s_q.rd_st == DPBS_BU_RUN)
         begin
            s_d.q      = rword_c;                                         // [R04]
            s_d.qv     = 1'b1;                                            // [R08]
            s_d.rd_cnt = s_q.rd_cnt + `DPBS_BEAT_ONE;                     // [R17]
            if (s_q.rd_cnt == `DPBS_LAST_BEAT)
            begin
               s_d.rd_st = DPBS_BU_IDLE;                                  // [R03]
            end
         end
         else
         begin
            // No word on this edge: flag drops, data keeps its last value
            s_d.qv = 1'b0;                                                // [R08]
         end
      end

      // Write engine: four words on consecutive edges, independent of reads [R10]
      if (wr_beat)
      begin
         s_d.wr_cnt = s_q.wr_cnt + `DPBS_BEAT_ONE;                        // [R17]
         if (s_q.wr_cnt == `DPBS_LAST_BEAT)
         begin
            s_d.wr_st = DPBS_BU_IDLE;                                     // [R03]
         end
      end
      // A new write address overrides the tail of the previous burst
      if (k_rise && (s_q.phase == DPBS_PH_WRITE) && !write_port_select_n && s_q.ctrl_en)
      begin
         s_d.wr_st   = DPBS_BU_RUN;                                       // [R15]
         s_d.wr_addr = addr;
         s_d.wr_cnt  = `DPBS_FIRST_BEAT;
      end

      // APB: answer prepared in setup, ready high for exactly the access cycle
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (apb_setup)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            `DPBS_OFS_CTRL:
            begin
               s_d.prdata[`DPBS_CTRL_EN_BIT] = s_q.ctrl_en;
            end
            `DPBS_OFS_STATUS:
            begin
               s_d.prdata[`DPBS_ST_RD_BIT]  = (s_q.rd_st == DPBS_BU_RUN) | (|s_q.rpv);
               s_d.prdata[`DPBS_ST_WR_BIT]  = (s_q.wr_st == DPBS_BU_RUN);
               s_d.prdata[`DPBS_ST_PLL_BIT] = pll_disable;
               s_d.prdata[`DPBS_ST_PH_BIT]  = (s_q.phase == DPBS_PH_WRITE);
            end
            `DPBS_OFS_RDCNT:
            begin
               s_d.prdata[`DPBS_CNT_W-1:0] = s_q.rd_bursts;
            end
            `DPBS_OFS_WRCNT:
            begin
               s_d.prdata[`DPBS_CNT_W-1:0] = s_q.wr_bursts;
            end
            default:
            begin
               // Unmapped: zero data and an error response
               s_d.pslverr = 1'b1;
            end
         endcase
      end

      // Only the control register is writable; status and counters ignore writes
      if (apb_wr && (paddr == `DPBS_OFS_CTRL))
      begin
         s_d.ctrl_en = pwdata[`DPBS_CTRL_EN_BIT];
      end
   end

   // State register; reset leaves both engines idle and the port enabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q           <= '0;
         s_q.phase     <= DPBS_PH_READ;
         s_q.rd_st     <= DPBS_BU_IDLE;
         s_q.wr_st     <= DPBS_BU_IDLE;
         s_q.ctrl_en   <= `DPBS_CTRL_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register [R12]
   assign data_out             = s_q.q;                                   // [R12]
   assign read_valid_flag      = s_q.qv;
   assign echo_timing_output   = s_q.echo_p;
   assign echo_timing_output_n = s_q.echo_n;
   assign prdata               = s_q.prdata;
   assign pready               = s_q.pready;
   assign pslverr              = s_q.pslverr;

endmodule

// [verification/dpbs_monitor.sv]
// Purpose: Concurrent checks on the ports of the burst memory device.
// Assumes: Timing inputs sampled by pclk; port enable tracked from APB writes.
// Notes:   Latency in edges of either timing input.
`timescale 1ns/1ps
`include "dpbs_consts.svh"

module dpbs_monitor
   import dpbs_pkg::*;
(
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [`DPBS_PADDR_W-1:0] paddr,
   input wire logic [31:0]              pwdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire logic                     k_in,
   input wire logic                     k_n_in,
   input wire logic                     read_port_select_n,
   input wire logic                     pll_disable,
   input wire logic [`DPBS_WORD_W-1:0]  data_out,
   input wire logic                     read_valid_flag,
   input wire logic                     echo_timing_output,
   input wire logic                     echo_timing_output_n
);
   logic       k_q, kn_q, slot_w_q, en_q;  // Timing samples, write slot next, port enable
   logic [9:0] hist_q;                     // Read captures, shifted once per edge
   wire  k_rise     = k_in && !k_q;
   wire  edge_seen  = k_rise || (k_n_in && !kn_q);
   wire  cap        = k_rise && !slot_w_q && !read_port_select_n && en_q;
   wire  due_now    = edge_seen && (pll_disable ? hist_q[4] : hist_q[1]);
   wire  burst_gone = pll_disable ? hist_q[8] : hist_q[5];
   wire  more_due   = pll_disable ? |hist_q[7:4] : |hist_q[4:1];

   // Edge history; a burst in flight sits at the bit of its edge distance
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {k_q, kn_q, slot_w_q, hist_q} <= '0;
         en_q <= `DPBS_CTRL_RST;
      end
      else
      begin
         k_q  <= k_in;
         kn_q <= k_n_in;
         slot_w_q <= slot_w_q ^ k_rise;
         hist_q   <= edge_seen ? {hist_q[8:0], cap} : hist_q;
         if (psel && penable && pready && pwrite && paddr == `DPBS_OFS_CTRL)
         begin
            en_q <= pwdata[0];
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_first_word; due_now; endsequence
   sequence s_burst_end; edge_seen && burst_gone && !more_due; endsequence

   AST_RD_LATENCY: assert property (s_first_word |=> read_valid_flag)
      else $error("No read word after the latency");
   AST_RD_EARLY: assert property ($rose(read_valid_flag) |-> $past(due_now))
      else $error("Read word came at the wrong edge");
   AST_RD_END: assert property (s_burst_end |=> !read_valid_flag)
      else $error("Read valid outlived four words");
   AST_RD_STALE: assert property (read_valid_flag |-> (|hist_q))
      else $error("Read valid with no read in flight");
   AST_OUT_ON_EDGE: assert property ($changed(data_out) |-> $past(edge_seen))
      else $error("Data moved off edge");
   AST_ECHO: assert property ({echo_timing_output, echo_timing_output_n} == $past({k_in, k_n_in}))
      else $error("Echo pair misaligned");
   AST_ECHO_ALIGN: assert property ($rose(read_valid_flag) |-> $rose(echo_timing_output) || $rose(echo_timing_output_n))
      else $error("First word off echo");
   AST_APB_READY: assert property (s_setup |=> pready ##1 !pready)
      else $error("APB answer late");
   AST_APB_ERR: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
      else $error("APB error flag wrong");
endmodule

bind dpbs_top dpbs_monitor u_mon (.*);

// [verification/dpbs_ctrl_model.sv]
// Purpose: Behavioural memory controller: timing pair, address, selects, write data.
// Assumes: Timing inputs run at a quarter of pclk and stay low through reset.
// Notes:   Bursts are launched by bench tasks.
`timescale 1ns/1ps

module dpbs_ctrl_model
   import dpbs_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   output logic                         k_in,
   output logic                         k_n_in,
   output logic [`DPBS_ADDR_W-1:0]      addr,
   output logic                         read_port_select_n,
   output logic                         write_port_select_n,
   output logic [`DPBS_LANES-1:0]       byte_write_select_n,
   output logic [`DPBS_WORD_W-1:0]      data_in
);
   logic [1:0] ph_q;    // Quarter of the timing period
   logic       slot_q;  // Slot of the next primary rise, high for write

   initial
   begin
      {addr, data_in} = '0;
      {read_port_select_n, write_port_select_n, byte_write_select_n} = '1;
   end

   // Primary and complement rise half a period apart so each edge carries a word
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {ph_q, slot_q, k_in, k_n_in} <= 5'h18;
      end
      else
      begin
         ph_q   <= ph_q + 2'h1;
         k_in   <= (ph_q == 2'h3) || (ph_q == 2'h0);
         k_n_in <= (ph_q == 2'h1) || (ph_q == 2'h2);
         slot_q <= slot_q ^ (ph_q == 2'h3);
      end
   end

   // Read address goes out with a read-slot primary rise
   task automatic read_burst(input logic [7:0] a);
      @(posedge pclk);
      while (!(ph_q == 2'h3 && !slot_q))
         @(posedge pclk);
      addr <= a;
      read_port_select_n <= 1'b0;
      @(posedge pclk);
      read_port_select_n <= 1'b1;
      addr <= ~a;
   endtask

   // Write address on a write-slot rise, then one word per following edge
   task automatic write_burst(input logic [7:0] a, input logic [3:0][35:0] w, input logic [3:0][3:0] m);
      @(posedge pclk);
      while (!(ph_q == 2'h3 && slot_q))
         @(posedge pclk);
      addr <= a;
      write_port_select_n <= 1'b0;
      fork
         for (int i = 0; i < 4; i++)
         begin
            repeat (2) @(posedge pclk);
            data_in <= w[i];
            byte_write_select_n <= ~m[i];
         end
      join_none
      @(posedge pclk);
      write_port_select_n <= 1'b1;
      addr <= ~a;
   endtask
endmodule

// [verification/test_dual_port_ddr_burst_sram_interface.sv]
// Purpose: Self-checking bench of the burst memory device with a controller model.
// Assumes: A reference array predicts every read word.
// Notes:   Locations from 0x80 are preloaded for concurrent traffic.
`timescale 1ns/1ps

module test_dual_port_ddr_burst_sram_interface
   import dpbs_pkg::*;
;
   logic          pclk, presetn, psel, penable, pwrite, pll_disable, pready, pslverr, rerr;
   logic [11:0]   paddr;
   logic [31:0]   pwdata, prdata, rdat;
   logic          k_in, k_n_in, read_port_select_n, write_port_select_n, read_valid_flag, e_q, en_q;
   logic          echo_timing_output, echo_timing_output_n;
   logic [7:0]    addr;
   logic [3:0]    byte_write_select_n;
   dpbs_word_type data_in, data_out;
   dpbs_word_type ref_mem [dpbs_widx_type];   // Reference contents
   dpbs_word_type exp_q[$], got_q[$];         // Expected and seen read words
   int            num_errors = 0, samples_checked = 0, rd_acc = 0, wr_acc = 0;

   always #2 pclk = ~pclk;

   dpbs_top u_dut (.*);
   dpbs_ctrl_model u_ctrl (.*);

   // A new word is present when a valid flag meets a fresh echo rise
   always @(posedge pclk)
   begin
      if (read_valid_flag === 1'b1 && ((echo_timing_output && !e_q) || (echo_timing_output_n && !en_q)))
         got_q.push_back(data_out);
      e_q  <= echo_timing_output;
      en_q <= echo_timing_output_n;
   end

   function automatic dpbs_word_type lane_mix(input dpbs_word_type o, input dpbs_word_type n, input logic [3:0] m);
      for (int i = 0; i < 4; i++)
         if (m[i])
            o[i*9 +: 9] = n[i*9 +: 9];
      return o;
   endfunction

   task automatic check(input dpbs_word_type seen, input dpbs_word_type exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Random burst; fresh locations get all lanes so no word stays unknown
   task automatic wr(input logic [7:0] a, input logic act);
      logic [3:0][35:0] w;
      logic [3:0][3:0]  m;
      for (int i = 0; i < 4; i++)
      begin
         w[i] = 36'({$urandom(), $urandom()});
         m[i] = 4'($urandom());
      end
      if (!ref_mem.exists({a, 2'h0}))
         m = '1;
      if (act)
      begin
         wr_acc++;
         for (int i = 0; i < 4; i++)
            ref_mem[{a, 2'(i)}] = lane_mix(ref_mem[{a, 2'(i)}], w[i], m[i]);
      end
      u_ctrl.write_burst(a, w, m);
   endtask

   task automatic rd(input logic [7:0] a, input logic act);
      if (act)
      begin
         rd_acc++;
         for (int i = 0; i < 4; i++)
            exp_q.push_back(ref_mem[{a, 2'(i)}]);
      end
      u_ctrl.read_burst(a);
   endtask

   task automatic drain();
      repeat (60) @(posedge pclk);
      check(36'(got_q.size()), 36'(exp_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0)
         check(got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (6000) @(posedge pclk);
      num_errors++;
      complete_run();
   end

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, pll_disable} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(10255));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      check(36'(rdat), 36'h1);
      apb(1'b0, 12'h010, 32'h0);
      check(36'({rerr, rdat}), 36'h100000000);
      for (int i = 0; i < 16; i++)
         wr(8'h80 + 8'(i % 8), 1'b1);
      wr(8'h90, 1'b1);
      rd(8'h90, 1'b1);
      for (int i = 0; i < 8; i++)
         rd(8'h80 + 8'(i), 1'b1);
      drain();
      fork
         repeat (6) wr(8'($urandom_range(0, 127)), 1'b1);
         repeat (6) rd(8'h80 + 8'($urandom_range(0, 7)), 1'b1);
      join
      drain();
      pll_disable <= 1'b1;
      wr(8'h91, 1'b1);
      rd(8'h91, 1'b1);
      for (int i = 0; i < 4; i++)
         rd(8'h84 + 8'(i), 1'b1);
      drain();
      apb(1'b1, 12'h000, 32'h0);
      wr(8'h81, 1'b0);
      rd(8'h81, 1'b0);
      apb(1'b1, 12'h000, 32'h1);
      rd(8'h81, 1'b1);
      drain();
      apb(1'b1, 12'h008, 32'hFFFF);
      apb(1'b0, 12'h008, 32'h0);
      check(36'(rdat), 36'(rd_acc));
      apb(1'b0, 12'h00C, 32'h0);
      check(36'(rdat), 36'(wr_acc));
      complete_run();
   end
endmodule
